/* File: rtl/mic_defs.vh */
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// register indexes; byte address is four times the index
`define MIC_IDX_ENABLE    8'h04
`define MIC_IDX_PENDING   8'h05
`define MIC_IDX_EDGE      8'h0C
`define MIC_IDX_CTRL      8'h20
`define MIC_IDX_SP        8'h21
`define MIC_IDX_EVTSTAT   8'h22
`define MIC_IDX_EVTMASK   8'h23

// source bit positions
`define MIC_BIT_PA0       0
`define MIC_BIT_PB0       1
`define MIC_BIT_T16       2
`define MIC_BIT_RSVD      3
`define MIC_BIT_CMP       4
`define MIC_BIT_PWM       5
`define MIC_BIT_T2        6
`define MIC_BIT_T3        7

// edge select fields
`define MIC_EDGE_PA0_LSB  0
`define MIC_EDGE_PB0_LSB  2
`define MIC_EDGE_T16_BIT  4
`define MIC_EDGE_RESET    5'h00
`define MIC_SEL_BOTH      2'h0
`define MIC_SEL_RISE      2'h1
`define MIC_SEL_FALL      2'h2

// entry vector and stack step
`define MIC_VECTOR        16'h0010
`define MIC_SP_STEP       8'h02

// reset values
`define MIC_ENABLE_RESET  8'h00
`define MIC_PENDING_RESET 8'h00
`define MIC_SP_RESET      8'h00
`define MIC_EVT_RESET     2'h0

// event status bits
`define MIC_EVT_ENTRY     0
`define MIC_EVT_RETURN    1

`endif

/* File: rtl/mic_edge_detect.v */
module mic_edge_detect (
  input  wire       ref_clk,   // system clock
  input  wire       rst,       // async reset, active high
  input  wire       level,     // source level
  input  wire [1:0] edgeSel,   // 00 both, 01 rising, 10 falling, 11 none
  output reg        hit        // one-cycle event pulse
);
`include "mic_defs.vh"

  reg prevQ;
  reg primedQ;

  // ---------------------------------------------------------------
  // previous level; first sample after reset only primes
  // ---------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevQ   <= 1'b0;
      primedQ <= 1'b0;
    end else begin
      prevQ   <= level;
      primedQ <= 1'b1;
    end
  end

  always @* begin
    hit = 1'b0;
    if (primedQ) begin
      case (edgeSel)
        `MIC_SEL_BOTH: hit = level ^ prevQ;
        `MIC_SEL_RISE: hit = level & ~prevQ;
        `MIC_SEL_FALL: hit = ~level & prevQ;
        default:       hit = 1'b0;
      endcase
    end
  end

endmodule

/* File: rtl/mic_interrupt_controller.v */
// The Wishbone interface to the registers is this design's own decision.
module mic_interrupt_controller #(
  parameter SP_W = 8                       // stack pointer width
) (
  input  wire            ref_clk,          // system clock, 40 MHz
  input  wire            rst,              // async reset, active high
  // wishbone classic slave
  input  wire            wb_cyc_i,         // bus cycle
  input  wire            wb_stb_i,         // strobe
  input  wire            wb_we_i,          // write enable
  input  wire [7:0]      wb_adr_i,         // word index
  input  wire [3:0]      wb_sel_i,         // byte lanes
  input  wire [31:0]     wb_dat_i,         // write data
  output wire [31:0]     wb_dat_o,         // read data
  output wire            wb_ack_o,         // acknowledge
  // event sources
  input  wire            portAPinZero,     // pin level
  input  wire            portBPinZero,     // pin level
  input  wire            sixteenBitTimer,  // overflow level
  input  wire            comparatorEvt,    // pulse
  input  wire            pwmGeneratorZero, // pulse
  input  wire            secondTimer,      // pulse
  input  wire            thirdTimer,       // pulse
  // core sequencer
  input  wire            instrBoundary,    // pulse: core may be diverted
  input  wire [15:0]     pcCurrent,        // counter to save on entry
  input  wire            globalEnableCmd,  // pulse: enable instruction
  input  wire            globalDisableCmd, // pulse: disable instruction
  input  wire            returnCmd,        // pulse: return instruction
  output wire            irqPending,       // level request to core
  output reg             pcLoad,           // pulse: load pcLoadValue
  output reg  [15:0]     pcLoadValue,      // new counter
  output wire            coreStall,        // core waits for pop
  // stack memory
  output reg             stackWe,          // pulse: write word
  output reg             stackRe,          // pulse: read word
  output reg  [SP_W-1:0] stackAddr,        // byte address
  output reg  [15:0]     stackWrData,      // pushed counter
  input  wire [15:0]     stackRdData,      // popped counter, next cycle
  // system interrupt
  output wire            sysIrq            // level, unmasked event pending
);
`include "mic_defs.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_POP  = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;

  reg  [7:0]      enableQ;
  reg  [7:0]      pendingQ;
  reg  [7:0]      pendingD;
  reg  [4:0]      edgeQ;
  reg             gieQ;
  reg             gieD;
  reg  [SP_W-1:0] spQ;
  reg  [SP_W-1:0] spD;
  reg  [1:0]      evtQ;
  reg  [1:0]      evtMaskQ;
  reg  [2:0]      stateQ;
  reg  [2:0]      stateD;
  reg             ackQ;
  reg  [31:0]     rdQ;
  reg  [31:0]     rdD;
  reg  [7:0]      srcEvt;
  wire            pa0Hit;
  wire            pb0Hit;
  wire            t16Hit;
  wire            wrEn;
  wire            take;
  wire            popDone;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [SP_W-1:0] spStep;
    input [SP_W-1:0] sp;
    input            up;
    begin
      if (up) begin
        spStep = sp + `MIC_SP_STEP;
      end else begin
        spStep = sp - `MIC_SP_STEP;
      end
    end
  endfunction

  function [7:0] lane0;
    input [31:0] d;
    begin
      lane0 = d[7:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // source edge detection
  // ---------------------------------------------------------------
  mic_edge_detect uPa0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (portAPinZero),
    .edgeSel (edgeQ[`MIC_EDGE_PA0_LSB+1:`MIC_EDGE_PA0_LSB]),
    .hit     (pa0Hit)
  );

  mic_edge_detect uPb0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (portBPinZero),
    .edgeSel (edgeQ[`MIC_EDGE_PB0_LSB+1:`MIC_EDGE_PB0_LSB]),
    .hit     (pb0Hit)
  );

  // single select bit maps 0 to rising, 1 to falling
  mic_edge_detect uT16 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (sixteenBitTimer),
    .edgeSel ({edgeQ[`MIC_EDGE_T16_BIT], ~edgeQ[`MIC_EDGE_T16_BIT]}),
    .hit     (t16Hit)
  );

  always @* begin
    srcEvt                = 8'h00;
    srcEvt[`MIC_BIT_PA0]  = pa0Hit;
    srcEvt[`MIC_BIT_PB0]  = pb0Hit;
    srcEvt[`MIC_BIT_T16]  = t16Hit;
    srcEvt[`MIC_BIT_CMP]  = comparatorEvt;
    srcEvt[`MIC_BIT_PWM]  = pwmGeneratorZero;
    srcEvt[`MIC_BIT_T2]   = secondTimer;
    srcEvt[`MIC_BIT_T3]   = thirdTimer;
  end

  // ---------------------------------------------------------------
  // wishbone slave: ack one cycle after strobe, write at ack edge
  // ---------------------------------------------------------------
  assign wrEn     = wb_cyc_i & wb_stb_i & wb_we_i & ackQ & wb_sel_i[0];
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdQ;

  always @* begin
    rdD = 32'h0000_0000;
    if (wb_adr_i == `MIC_IDX_ENABLE) begin
      rdD[7:0] = enableQ;
    end else if (wb_adr_i == `MIC_IDX_PENDING) begin
      rdD[7:0] = pendingQ & ~(8'h01 << `MIC_BIT_RSVD);
    end else if (wb_adr_i == `MIC_IDX_CTRL) begin
      rdD[0] = gieQ;
    end else if (wb_adr_i == `MIC_IDX_SP) begin
      rdD[SP_W-1:0] = spQ;
    end else if (wb_adr_i == `MIC_IDX_EVTSTAT) begin
      rdD[1:0] = evtQ;
    end else if (wb_adr_i == `MIC_IDX_EVTMASK) begin
      rdD[1:0] = evtMaskQ;
    end else begin
      rdD = 32'h0000_0000;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ackQ <= 1'b0;
      rdQ  <= 32'h0000_0000;
    end else begin
      ackQ <= wb_cyc_i & wb_stb_i & ~ackQ;
      rdQ  <= rdD;
    end
  end

  // ---------------------------------------------------------------
  // enable, edge select, event mask registers
  // ---------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enableQ  <= `MIC_ENABLE_RESET;
      edgeQ    <= `MIC_EDGE_RESET;
      evtMaskQ <= `MIC_EVT_RESET;
    end else if (wrEn) begin
      if (wb_adr_i == `MIC_IDX_ENABLE) begin
        enableQ <= lane0(wb_dat_i);
      end else if (wb_adr_i == `MIC_IDX_EDGE) begin
        edgeQ <= wb_dat_i[4:0];
      end else if (wb_adr_i == `MIC_IDX_EVTMASK) begin
        evtMaskQ <= wb_dat_i[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pending flags: event set wins over a software write
  // ---------------------------------------------------------------
  always @* begin
    pendingD = pendingQ;
    if (wrEn && (wb_adr_i == `MIC_IDX_PENDING)) begin
      pendingD = lane0(wb_dat_i);
    end
    pendingD = pendingD | srcEvt;
    pendingD[`MIC_BIT_RSVD] = 1'b0;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pendingQ <= `MIC_PENDING_RESET;
    end else begin
      pendingQ <= pendingD;
    end
  end

  // ---------------------------------------------------------------
  // request to core
  // ---------------------------------------------------------------
  assign irqPending = gieQ & (|(pendingQ & enableQ)) & stateQ[0];
  assign take       = irqPending & instrBoundary;
  assign popDone    = stateQ[2];
  assign coreStall  = ~stateQ[0];

  // ---------------------------------------------------------------
  // entry and return sequencer
  // ---------------------------------------------------------------
  always @* begin
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: begin
        if (!take && returnCmd) begin
          stateD = ST_POP;
        end
      end
      ST_POP: begin
        stateD = ST_LOAD;
      end
      ST_LOAD: begin
        stateD = ST_IDLE;
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always @* begin
    gieD = gieQ;
    spD  = spQ;
    if (wrEn && (wb_adr_i == `MIC_IDX_CTRL)) begin
      gieD = wb_dat_i[0];
    end
    if (wrEn && (wb_adr_i == `MIC_IDX_SP)) begin
      spD = wb_dat_i[SP_W-1:0];
    end
    if (globalEnableCmd) begin
      gieD = 1'b1;
    end
    if (globalDisableCmd) begin
      gieD = 1'b0;
    end
    if (take) begin
      gieD = 1'b0;
      spD  = spStep(spQ, 1'b1);
    end
    if (popDone) begin
      gieD = 1'b1;
      spD  = spStep(spQ, 1'b0);
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateQ      <= ST_IDLE;
      gieQ        <= 1'b0;
      spQ         <= `MIC_SP_RESET;
      stackWe     <= 1'b0;
      stackRe     <= 1'b0;
      stackAddr   <= {SP_W{1'b0}};
      stackWrData <= 16'h0000;
      pcLoad      <= 1'b0;
      pcLoadValue <= 16'h0000;
    end else begin
      stateQ  <= stateD;
      gieQ    <= gieD;
      spQ     <= spD;
      stackWe <= take;
      stackRe <= stateQ[0] & ~take & returnCmd;
      pcLoad  <= take | stateQ[2];
      if (take) begin
        stackAddr   <= spQ;
        stackWrData <= pcCurrent;
        pcLoadValue <= `MIC_VECTOR;
      end else if (stateQ[0] && returnCmd) begin
        stackAddr <= spStep(spQ, 1'b0);
      end else if (stateQ[2]) begin
        // popped word stands only in the cycle after the read
        pcLoadValue <= stackRdData;
      end
    end
  end

  // ---------------------------------------------------------------
  // system interrupt: entry and return events, write one to clear
  // ---------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evtQ <= `MIC_EVT_RESET;
    end else begin
      evtQ <= (evtQ & ~((wrEn && (wb_adr_i == `MIC_IDX_EVTSTAT)) ? wb_dat_i[1:0] : 2'h0))
              | {popDone, take};
    end
  end

  assign sysIrq = |(evtQ & evtMaskQ);

endmodule

/* File: verif/mic_stack_model.sv */
// --------------------------------
// stack memory seen by the core
// --------------------------------
module mic_stack_model #(
  parameter SP_W = 8                        // address width
) (
  input  wire logic            ref_clk,     // clock
  input  wire logic            stackWe,     // write word
  input  wire logic            stackRe,     // read word
  input  wire logic [SP_W-1:0] stackAddr,   // byte address
  input  wire logic [15:0]     stackWrData, // pushed word
  output logic      [15:0]     stackRdData  // popped word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:(1<<SP_W)-1];
  initial stackRdData = 16'hA5A5;
  // one word per level; data only valid the cycle after a read
  always @(posedge ref_clk) begin
    if (stackWe) mem[stackAddr] <= stackWrData;
    stackRdData <= stackRe ? mem[stackAddr] : ~stackRdData;
  end
endmodule

/* File: verif/mic_interrupt_controller_chk.sv */
module mic_interrupt_controller_chk #(
  parameter SP_W = 8                        // stack pointer width
) (
  input wire logic            ref_clk,      // clock
  input wire logic            rst,          // reset
  input wire logic            wb_cyc_i,     // bus cycle
  input wire logic            wb_stb_i,     // strobe
  input wire logic            wb_ack_o,     // acknowledge
  input wire logic            instrBoundary, // boundary
  input wire logic [15:0]     pcCurrent,    // counter
  input wire logic            globalDisableCmd, // disable
  input wire logic            irqPending,   // request
  input wire logic            pcLoad,       // load pulse
  input wire logic [15:0]     pcLoadValue,  // new counter
  input wire logic            coreStall,    // stall
  input wire logic            stackWe,      // push
  input wire logic            stackRe,      // pop
  input wire logic [SP_W-1:0] stackAddr,    // address
  input wire logic [15:0]     stackWrData,  // push data
  input wire logic [15:0]     stackRdData   // pop data
);
  localparam logic [SP_W-1:0] STEP = 2;
  logic [SP_W-1:0] nxtQ;
  // ----------------------------
  // next push address tracker
  // ----------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) nxtQ <= '0;
    else if (stackWe) nxtQ <= stackAddr + STEP;
    else if (stackRe) nxtQ <= stackAddr;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ENTRY: assert property (irqPending && instrBoundary |=> stackWe && pcLoad
    && pcLoadValue == 16'h0010 && stackWrData == $past(pcCurrent)) else $error("bad entry");
  AST_GIE_OFF: assert property (stackWe |-> !irqPending) else $error("request during entry");
  AST_GDIS: assert property (globalDisableCmd |=> !irqPending) else $error("request when off");
  AST_POP: assert property (stackRe |-> coreStall ##1 coreStall ##1
    pcLoad && pcLoadValue == $past(stackRdData)) else $error("bad return");
  AST_PUSH_SP: assert property (stackWe |-> stackAddr == nxtQ) else $error("push address");
  AST_POP_SP: assert property (stackRe |-> stackAddr == nxtQ - STEP) else $error("pop address");
  AST_LOAD_ONE: assert property (pcLoad |=> !pcLoad) else $error("load too long");
endmodule

bind mic_interrupt_controller mic_interrupt_controller_chk #(.SP_W(SP_W)) chk (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .instrBoundary(instrBoundary), .pcCurrent(pcCurrent), .globalDisableCmd(globalDisableCmd),
  .irqPending(irqPending), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .coreStall(coreStall),
  .stackWe(stackWe), .stackRe(stackRe), .stackAddr(stackAddr), .stackWrData(stackWrData),
  .stackRdData(stackRdData));

/* File: verif/mic_interrupt_controller_tb.sv */
`include "mic_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module mic_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0;
  logic [6:0]  ev = 0;
  logic [3:0]  cmd = 0;
  logic [15:0] pc = 0, v;
  logic [7:0]  r;
  logic [8:0]  e;
  logic [15:0] pe;
  logic [8:0]  busQ[$];
  logic [15:0] pcQ[$];
  wire  [31:0] rdat;
  wire  [15:0] pcLoadValue, stackWrData, stackRdData;
  wire  [7:0]  stackAddr;
  wire         ack, irqPending, pcLoad, coreStall, stackWe, stackRe, sysIrq;
  int          n_mismatch = 0, comparisons = 0, i, s;
  mic_interrupt_controller dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .portAPinZero(ev[0]), .portBPinZero(ev[1]), .sixteenBitTimer(ev[2]), .comparatorEvt(ev[3]),
    .pwmGeneratorZero(ev[4]), .secondTimer(ev[5]), .thirdTimer(ev[6]), .instrBoundary(cmd[0]),
    .pcCurrent(pc), .globalEnableCmd(cmd[1]), .globalDisableCmd(cmd[2]), .returnCmd(cmd[3]),
    .irqPending(irqPending), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .coreStall(coreStall),
    .stackWe(stackWe), .stackRe(stackRe), .stackAddr(stackAddr), .stackWrData(stackWrData),
    .stackRdData(stackRdData), .sysIrq(sysIrq));
  mic_stack_model stk (.ref_clk(ref_clk), .stackWe(stackWe), .stackRe(stackRe),
    .stackAddr(stackAddr), .stackWrData(stackWrData), .stackRdData(stackRdData));
  always #12.5 ref_clk = ~ref_clk;
  // ----------------------------
  // tasks
  // ----------------------------
  task final_report;
    $display("compared %0d, mismatched %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task bus(input logic w, input logic [7:0] a, d, ex);
    int k;
    @(posedge ref_clk);
    {cyc, stb, we, adr} <= {2'h3, w, a};
    dat <= {24'h0, d};
    busQ.push_back({w, ex});
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      n_mismatch++;
      final_report;
    end
    {cyc, stb} <= 2'h0;
  endtask
  task wr(input logic [7:0] a, d);
    bus(1'b1, a, d, 8'h00);
  endtask
  task rd(input logic [7:0] a, ex);
    bus(1'b0, a, 8'h00, ex);
  endtask
  task pulse(input logic [3:0] c, input logic [6:0] p);
    @(posedge ref_clk);
    cmd <= c;
    ev <= ev | p;
    @(posedge ref_clk);
    cmd <= 4'h0;
    ev <= ev & ~p;
  endtask
  // ----------------------------
  // result watcher
  // ----------------------------
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && busQ.size() > 0) begin
      e = busQ.pop_front();
      if (!e[8]) `CHK("readData", {24'h0, e[7:0]}, rdat)
    end
    if (pcLoad === 1'b1) begin
      pe = pcQ.size() ? pcQ.pop_front() : 16'hXXXX;
      `CHK("pcLoad", pe, pcLoadValue)
    end
  end
  initial begin
    i = $urandom(70);
    tick(8);
    rst <= 0;
    r = $urandom;
    wr(`MIC_IDX_ENABLE, r);
    rd(`MIC_IDX_ENABLE, r);
    wr(`MIC_IDX_PENDING, 8'hFF);
    rd(`MIC_IDX_PENDING, 8'hF7);
    rd(`MIC_IDX_EDGE, 8'h00);
    rd(8'h30, 8'h00);
    $display("test registers done");
    wr(`MIC_IDX_ENABLE, 8'h00);
    for (i = 3; i < 7; i++) begin
      wr(`MIC_IDX_PENDING, 8'h00);
      pulse(4'h0, 7'h01 << i);
      tick(2);
      rd(`MIC_IDX_PENDING, 8'h01 << (i + 1));
    end
    $display("test pulse sources done");
    for (s = 0; s < 4; s++) begin
      wr(`MIC_IDX_EDGE, {3'h0, s[0], s[1:0], s[1:0]});
      wr(`MIC_IDX_PENDING, 8'h00);
      @(posedge ref_clk) ev[2:0] <= 3'h7;
      tick(2);
      rd(`MIC_IDX_PENDING, {5'h0, !s[0], {2{s < 2}}});
      wr(`MIC_IDX_PENDING, 8'h00);
      @(posedge ref_clk) ev[2:0] <= 3'h0;
      tick(2);
      rd(`MIC_IDX_PENDING, {5'h0, s[0], {2{s == 0 || s == 2}}});
    end
    $display("test edge select done");
    wr(`MIC_IDX_EDGE, 8'h01);
    wr(`MIC_IDX_PENDING, 8'h00);
    pulse(4'h2, 7'h00);
    @(posedge ref_clk) ev[0] <= 1'b1;
    tick(2);
    `CHK("irqPending", 1'b0, irqPending)
    wr(`MIC_IDX_ENABLE, 8'h01);
    tick(1);
    `CHK("irqPending", 1'b1, irqPending)
    pulse(4'h4, 7'h00);
    tick(1);
    `CHK("irqPending", 1'b0, irqPending)
    pulse(4'h2, 7'h00);
    tick(1);
    `CHK("irqPending", 1'b1, irqPending)
    v = $urandom;
    pc <= v;
    pcQ.push_back(`MIC_VECTOR);
    pulse(4'h1, 7'h00);
    tick(2);
    `CHK("irqPending", 1'b0, irqPending)
    pcQ.push_back(v);
    // only the serviced pin flag is pending here
    wr(`MIC_IDX_PENDING, 8'h00);
    pulse(4'h8, 7'h00);
    tick(4);
    @(posedge ref_clk) ev[0] <= 1'b0;
    pulse(4'h0, 7'h01);
    tick(2);
    `CHK("irqPending", 1'b1, irqPending)
    $display("test entry and return done");
    rd(`MIC_IDX_EVTSTAT, 8'h03);
    `CHK("sysIrq", 1'b0, sysIrq)
    wr(`MIC_IDX_EVTMASK, 8'h01);
    tick(1);
    `CHK("sysIrq", 1'b1, sysIrq)
    wr(`MIC_IDX_EVTSTAT, 8'h01);
    tick(1);
    `CHK("sysIrq", 1'b0, sysIrq)
    rd(`MIC_IDX_EVTSTAT, 8'h02);
    tick(3);
    `CHK("pcQueue", 0, pcQ.size())
    $display("test event interrupt done");
    final_report;
  end
endmodule
